// >>> fan_alarm_regs.svh
// register offsets, field positions and reset values for the alarm block
// assumes an avalon-mm slave with word addressing by byte address / 4
`ifndef FAN_ALARM_REGS_SVH
`define FAN_ALARM_REGS_SVH

`define ALARM_STATUS_IDX         8'h5a
`define NVM_XFER_CTRL_IDX        8'h5b
`define SET_POINTS_IDX           8'h60
`define MEASURE_IDX              8'h61
`define FAN_THRESH_IDX           8'h62
`define FAN_CONFIG_IDX           8'h63
`define ADDR_W                   10

`define ST_REMOTE_HIGH_BIT       3
`define ST_REMOTE_OT_BIT         2
`define ST_FAN_TWO_BIT           1
`define ST_FAN_ONE_BIT           0

`define XFER_DIR_BIT             7
`define XFER_BLOCKS_MSB          4
`define XFER_WRITE_MASK          8'h9f
`define XFER_RESET               8'h00
`define STATUS_RESET             4'h0
`define BYTE_RESET               8'h00
`define WORD_RESET               16'h0000
`define THRESH_RESET             16'hffff

`endif

// >>> fan_alarm_pkg.sv
// shared types for the fan alarm and nvm transfer register block
// assumes nothing beyond a systemverilog compiler
package fan_alarm_pkg;
  typedef enum logic [2:0] {
    bus_idle = 3'b001,
    bus_ack  = 3'b010,
    bus_wait = 3'b100
  } bus_state_t;
endpackage

// >>> fan_alarm_status_and_nvm_transfer.sv
// alarm status byte (lower half) and ram/eeprom transfer control byte
// assumes clk_sys domain, tach counts from a counter block in the same
// clock domain, and fan sense pins arriving asynchronously
//
// Operation
// - remote high alarm when temperature above set point
// - overtemp alarm when remote above overtemp point
// - fan two alarm low while count within threshold
// - fan two alarm on slow, stopped or overflow
// - fan one alarm low while count within threshold
// - fan one alarm on slow, stopped or overflow
// - rotation-detect mode: running level raises no alarm
// - control bit 7 picks transfer direction
// - control bits 0-4 select 16-byte blocks
// - status read clears, still-present fault sets again
`include "fan_alarm_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module fan_alarm_status_and_nvm_transfer #(
  parameter int COUNT_W = 16
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // avalon-mm slave, byte address
  input  wire logic [`ADDR_W-1:0] address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  input  wire logic [3:0]         byteenable,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  output logic [1:0]              response,
  // measurement inputs from same-domain logic
  input  wire logic               temp_valid,
  input  wire logic               count_valid,
  input  wire logic [COUNT_W-1:0] fan_one_count,
  input  wire logic [COUNT_W-1:0] fan_two_count,
  input  wire logic               fan_one_overflow,
  input  wire logic               fan_two_overflow,
  // asynchronous rotation-detect pins
  input  wire logic               first_fan_sense_input,
  input  wire logic               second_fan_sense_input,
  // transfer request to the eeprom engine
  output logic                    xfer_start,
  output logic                    xfer_load,
  output logic [4:0]              xfer_blocks
);

  // ==========================================================
  // register storage
  logic [3:0]         status;
  logic [7:0]         xfer_ctrl;
  logic [7:0]         remote_high_point;
  logic [7:0]         remote_ot_point;
  logic [15:0]        remote_temp;
  logic [COUNT_W-1:0] count_thresh;
  logic [1:0]         rd_mode;     // 1 = rotation-detect on that input
  logic [1:0]         rd_polarity; // level meaning running
  fan_alarm_pkg::bus_state_t bus_state;

  // ==========================================================
  // pin synchronisers
  logic [1:0] sense_meta;
  logic [1:0] sense_sync;

  // two flops before anything reads the fan sense pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_meta <= 2'h0;
      sense_sync <= 2'h0;
    end else begin
      sense_meta <= {second_fan_sense_input, first_fan_sense_input};
      sense_sync <= sense_meta;
    end
  end

  // ==========================================================
  // fault detection
  logic signed [8:0] remote_whole;
  logic              remote_high_fault;
  logic              remote_ot_fault;
  logic [1:0]        fan_fault;
  logic [1:0]        fan_running;

  // integer part of remote reading compared as signed degrees
  assign remote_whole = {remote_temp[15], remote_temp[15:8]};
  assign remote_high_fault = temp_valid &&
    (remote_whole > $signed({remote_high_point[7], remote_high_point})
     || (remote_whole == $signed({remote_high_point[7],
         remote_high_point}) && remote_temp[7:5] != 3'h0));
  assign remote_ot_fault = temp_valid &&
    (remote_whole > $signed({remote_ot_point[7], remote_ot_point})
     || (remote_whole == $signed({remote_ot_point[7],
         remote_ot_point}) && remote_temp[7:5] != 3'h0));
  assign fan_running = ~(sense_sync ^ rd_polarity);

  // per fan: pulse mode compares count, rd mode looks at level
  always_comb begin
    fan_fault[0] = rd_mode[0] ? ~fan_running[0] :
      (count_valid && (fan_one_overflow ||
       fan_one_count > count_thresh));
    fan_fault[1] = rd_mode[1] ? ~fan_running[1] :
      (count_valid && (fan_two_overflow ||
       fan_two_count > count_thresh));
  end

  // ==========================================================
  // bus decode
  logic [7:0] idx;
  logic       hit;
  logic       take_write;
  logic       take_read;

  assign idx = address[`ADDR_W-1:2];
  assign take_write = write && bus_state == fan_alarm_pkg::bus_idle;
  assign take_read  = read  && bus_state == fan_alarm_pkg::bus_idle;
  assign hit = idx == `ALARM_STATUS_IDX || idx == `NVM_XFER_CTRL_IDX ||
               idx == `SET_POINTS_IDX   || idx == `MEASURE_IDX ||
               idx == `FAN_THRESH_IDX   || idx == `FAN_CONFIG_IDX;

  // one wait cycle, then ack; back to idle through wait after two fixed cycles, request not watched
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_state   <= fan_alarm_pkg::bus_idle;
      waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        fan_alarm_pkg::bus_idle: begin
          if (read || write) begin
            bus_state   <= fan_alarm_pkg::bus_ack;
            waitrequest <= 1'b0;
          end
        end
        fan_alarm_pkg::bus_ack: begin
          bus_state   <= fan_alarm_pkg::bus_wait;
          waitrequest <= 1'b1;
        end
        fan_alarm_pkg::bus_wait: begin
          bus_state <= fan_alarm_pkg::bus_idle;
        end
        default: begin
          bus_state   <= fan_alarm_pkg::bus_idle;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // read data and response, latched when request is taken
  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = 32'h0;
    case (idx)
      `ALARM_STATUS_IDX:  next_readdata = {28'h0, status};
      `NVM_XFER_CTRL_IDX: next_readdata = {24'h0, xfer_ctrl};
      `SET_POINTS_IDX:
        next_readdata = {16'h0, remote_ot_point, remote_high_point};
      `MEASURE_IDX:       next_readdata = {16'h0, remote_temp};
      `FAN_THRESH_IDX:
        next_readdata = {{(32-COUNT_W){1'b0}}, count_thresh};
      `FAN_CONFIG_IDX:
        next_readdata = {28'h0, rd_polarity, rd_mode};
      default:            next_readdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readdata <= 32'h0;
      response <= 2'h0;
    end else if (take_read || take_write) begin
      readdata <= take_read ? next_readdata : 32'h0;
      response <= hit ? 2'h0 : 2'h3; // decode error on unmapped
    end
  end

  // ==========================================================
  // status: sticky alarms, clear on read, live fault wins
  logic status_read;
  assign status_read = take_read && idx == `ALARM_STATUS_IDX;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= `STATUS_RESET;
    end else begin
      status <= (status_read ? 4'h0 : status) |
        {remote_high_fault, remote_ot_fault, fan_fault[1],
         fan_fault[0]};
    end
  end

  // ==========================================================
  // transfer control: write captures, read clears, reserved held 0
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xfer_ctrl <= `XFER_RESET;
    end else if (take_write && idx == `NVM_XFER_CTRL_IDX &&
                 byteenable[0]) begin
      xfer_ctrl <= writedata[7:0] & `XFER_WRITE_MASK;
    end else if (take_read && idx == `NVM_XFER_CTRL_IDX) begin
      xfer_ctrl <= `XFER_RESET;
    end
  end

  // one-cycle start toward the eeprom engine on a valid write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xfer_start  <= 1'b0;
      xfer_load   <= 1'b0;
      xfer_blocks <= 5'h0;
    end else begin
      xfer_start <= take_write && idx == `NVM_XFER_CTRL_IDX &&
        byteenable[0] &&
        writedata[`XFER_BLOCKS_MSB:0] != 5'h0;
      if (take_write && idx == `NVM_XFER_CTRL_IDX && byteenable[0]) begin
        xfer_load   <= writedata[`XFER_DIR_BIT];
        xfer_blocks <= writedata[`XFER_BLOCKS_MSB:0];
      end
    end
  end

  // ==========================================================
  // software-loaded set points, reading and fan configuration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      remote_high_point <= `BYTE_RESET;
      remote_ot_point   <= `BYTE_RESET;
      remote_temp       <= `WORD_RESET;
      count_thresh      <= COUNT_W'(`THRESH_RESET);
      rd_mode           <= 2'h0;
      rd_polarity       <= 2'h0;
    end else if (take_write) begin
      case (idx)
        `SET_POINTS_IDX: begin
          if (byteenable[0]) remote_high_point <= writedata[7:0];
          if (byteenable[1]) remote_ot_point   <= writedata[15:8];
        end
        `MEASURE_IDX: begin
          if (byteenable[0]) remote_temp[7:0]  <= writedata[7:0];
          if (byteenable[1]) remote_temp[15:8] <= writedata[15:8];
        end
        `FAN_THRESH_IDX: begin
          count_thresh <= writedata[COUNT_W-1:0];
        end
        `FAN_CONFIG_IDX: begin
          if (byteenable[0]) begin
            rd_mode     <= writedata[1:0];
            rd_polarity <= writedata[3:2];
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule // fan_alarm_status_and_nvm_transfer

`default_nettype wire

// >>> fan_alarm_asserts.sv
// checker: bus handshake, responses and transfer request of the block
// assumes it is bound onto the block; one clock, synchronous reset
`include "fan_alarm_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module fan_alarm_asserts (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic [`ADDR_W-1:0] address,
  input wire logic               read,
  input wire logic               write,
  input wire logic [31:0]        writedata,
  input wire logic [3:0]         byteenable,
  input wire logic [31:0]        readdata,
  input wire logic               waitrequest,
  input wire logic [1:0]         response,
  input wire logic               xfer_start,
  input wire logic               xfer_load,
  input wire logic [4:0]         xfer_blocks
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // answer strobe and register decode
  wire logic       done = !waitrequest;
  wire logic [7:0] idx  = address[9:2];
  wire logic       ctl  = idx == `NVM_XFER_CTRL_IDX;
  wire logic       ok   = idx inside {8'h5a, 8'h5b, [8'h60:8'h63]};
  // ======================================
  // assertions
  a_wait_gap: assert property (done |=> waitrequest[*2])
    else $error("answer not followed by two idle cycles");
  a_wait_bound: assert property ((read || write) && !done |-> ##[1:3] done)
    else $error("request not answered in time");
  a_resp_okay: assert property (done && (read || write) && ok |-> !response)
    else $error("mapped access not okay");
  a_resp_unmapped: assert property (done && read && !ok
    |-> response == 2'h3 && readdata == 32'h0)
    else $error("unmapped read not refused");
  a_ctrl_reserved: assert property (done && read && ctl
    |-> readdata[31:8] == 24'h0 && readdata[6:5] == 2'h0)
    else $error("reserved control bits not zero");
  a_start_cause: assert property (xfer_start |-> write && ctl
    && writedata[4:0] != 5'h0 && xfer_blocks == writedata[4:0])
    else $error("start without block write");
  a_start_dir: assert property (xfer_start |-> xfer_load == writedata[7])
    else $error("transfer direction wrong");
  a_start_taken: assert property (done && write && ctl && byteenable[0]
    && writedata[4:0] != 5'h0 |-> xfer_start ##1 !xfer_start)
    else $error("start pulse missing or long");
  a_xfer_hold: assert property ($changed({xfer_load, xfer_blocks})
    |-> $past(write) && $past(idx) == `NVM_XFER_CTRL_IDX)
    else $error("transfer fields moved without write");
  c_start: cover property (xfer_start && xfer_load);
  c_store: cover property (xfer_start && !xfer_load);
  c_refused: cover property (done && response == 2'h3);
endmodule // fan_alarm_asserts
bind fan_alarm_status_and_nvm_transfer fan_alarm_asserts i_fan_alarm_asserts (
  .clk_sys, .rst, .address, .read, .write, .writedata, .byteenable,
  .readdata, .waitrequest, .response, .xfer_start, .xfer_load, .xfer_blocks);
`default_nettype wire

// >>> fan_pair_model.sv
// partner model: two fans feeding tach counts and rotation pins
// assumes the bench commands each fan's count and spin state
`timescale 1ns/1ns
`default_nettype none
module fan_pair_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [15:0] want_one,
  input  wire logic [15:0] want_two,
  input  wire logic [1:0]  spin,
  output logic             count_valid,
  output logic [15:0]      fan_one_count,
  output logic [15:0]      fan_two_count,
  output logic             fan_one_overflow,
  output logic             fan_two_overflow,
  output logic             first_fan_sense_input,
  output logic             second_fan_sense_input
);
  // counts settle a clock after a new speed; a full count overflows
  always_ff @(posedge clk_sys) begin
    count_valid      <= !rst;
    fan_one_count    <= want_one;
    fan_two_count    <= want_two;
    fan_one_overflow <= &want_one;
    fan_two_overflow <= &want_two;
  end
  // rotation pins follow the spin state
  assign first_fan_sense_input  = spin[0];
  assign second_fan_sense_input = spin[1];
endmodule // fan_pair_model
`default_nettype wire

// >>> test_fan_alarm_status_and_nvm_transfer.sv
// testbench: alarm status and transfer control through the register bus
// assumes the block, the fan model and the checker are compiled first
`include "fan_alarm_regs.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  n_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module test_fan_alarm_status_and_nvm_transfer;
  logic        clk_sys = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0;
  logic [9:0]  address = 10'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [15:0] want_one = 16'h0, want_two = 16'h0, c1, c2;
  logic [1:0]  spin = 2'h0, response;
  logic [4:0]  xfer_blocks;
  logic [3:0]  last = 4'h0;
  logic        waitrequest, xfer_start, xfer_load, cv, o1, o2, s1, s2;
  logic        temp_valid = 1'h0;
  int          n_errors = 0, check_count = 0, n_starts = 0, i;
  logic [43:0] tbl [8] = '{44'h3c03e803e88, 44'h4703e803e8c,
    44'h4603e803e88, 44'h3203e803e80, 44'h0003e903e81,
    44'h0003e803e92, 44'h00ffff03e81, 44'h0003e8ffff2};
  fan_alarm_status_and_nvm_transfer i_fan_alarm_status_and_nvm_transfer (
    .clk_sys, .rst, .address, .read, .write, .writedata, .byteenable(4'hf),
    .readdata, .waitrequest, .response, .temp_valid, .count_valid(cv),
    .fan_one_count(c1), .fan_two_count(c2), .fan_one_overflow(o1),
    .fan_two_overflow(o2), .first_fan_sense_input(s1),
    .second_fan_sense_input(s2), .xfer_start, .xfer_load, .xfer_blocks);
  fan_pair_model i_fan_pair_model (.clk_sys, .rst, .want_one, .want_two,
    .spin, .count_valid(cv), .fan_one_count(c1), .fan_two_count(c2),
    .fan_one_overflow(o1), .fan_two_overflow(o2),
    .first_fan_sense_input(s1), .second_fan_sense_input(s2));
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (xfer_start === 1'h1) n_starts++;
  // one bus access held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] ix, input [31:0] d);
    int k;
    @(posedge clk_sys);
    read <= !w;
    write <= w;
    address <= {ix, 2'h0};
    writedata <= d;
    for (k = 0; k < 20 && waitrequest !== 1'h0; k++) @(posedge clk_sys);
    if (k == 20) begin
      n_errors++;
      wrap_up();
    end
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    // reset value and unmapped place
    acc(0, `NVM_XFER_CTRL_IDX, 0);
    `CHK("ctrl reset", 32'h0, q)
    acc(0, 8'h70, 0);
    `CHK("unmapped", 34'h300000000, {response, q})
    acc(0, `ALARM_STATUS_IDX, 0);
    // temperature and fan alarms, sticky until read
    acc(1, `SET_POINTS_IDX, 32'h4632);
    acc(1, `FAN_THRESH_IDX, 32'h3e8);
    temp_valid <= 1'h1;
    for (i = 0; i < 8; i++) begin
      want_one <= tbl[i][35:20];
      want_two <= tbl[i][19:4];
      acc(1, `MEASURE_IDX, {16'h0, tbl[i][43:36], 8'h0});
      acc(0, `ALARM_STATUS_IDX, 0);
      `CHK("sticky", {28'h0, tbl[i][3:0] | last}, q)
      acc(0, `ALARM_STATUS_IDX, 0);
      `CHK("alarm", {28'h0, tbl[i][3:0]}, q)
      last = tbl[i][3:0];
    end
    // rotation-detect: running level high on both pins
    acc(1, `FAN_CONFIG_IDX, 32'hf);
    for (i = 1; i < 4; i++) begin
      spin <= i[1:0];
      // the pin reaches the alarm two flops late: first read sees old level
      acc(0, `ALARM_STATUS_IDX, 0);
      acc(0, `ALARM_STATUS_IDX, 0);
      acc(0, `ALARM_STATUS_IDX, 0);
      `CHK("rotation", {30'h0, ~i[1:0]}, q)
    end
    $display("alarm tests done");
    // each block select with alternating direction
    for (i = 0; i < 5; i++) begin
      acc(1, `NVM_XFER_CTRL_IDX, {24'h0, !i[0], 2'h3, 5'h1 << i});
      `CHK("xfer", {!i[0], 5'h1 << i}, {xfer_load, xfer_blocks})
      acc(0, `NVM_XFER_CTRL_IDX, 0);
      `CHK("ctrl", {24'h0, !i[0], 2'h0, 5'h1 << i}, q)
    end
    acc(0, `NVM_XFER_CTRL_IDX, 0);
    `CHK("ctrl cleared", 32'h0, q)
    acc(1, `NVM_XFER_CTRL_IDX, 32'h80);
    `CHK("starts", 5, n_starts)
    $display("transfer tests done");
    wrap_up();
  end
endmodule // test_fan_alarm_status_and_nvm_transfer
`default_nettype wire
